// ### perf_counter_csr_unit.v
// performance counters and identification registers reached by csr access
`timescale 1ns/1ps
`include "perf_counter_regs.vh"
module perf_counter_csr_unit
#(
   parameter EVENT_COUNTER_QUANTITY = 1,
   parameter [24:0] MAKER_BANK_COUNT  = 25'h0000001,  // arbitrary value
   parameter [6:0]  MAKER_CODE_BYTE   = 7'h55,        // arbitrary value
   parameter [31:0] ARCH_ID_VALUE     = 32'h0000abcd, // arbitrary value
   parameter [3:0]  IMPL_MAJOR        = 4'h0,
   parameter [3:0]  IMPL_MINOR        = 4'h0
)
(
   // gated core clock and reset
   input  wire        I_REF_CLK,
   input  wire        I_RST,
   // csr access port
   input  wire        I_CSR_EN,
   input  wire        I_CSR_WE,
   input  wire [11:0] I_CSR_ADDR,
   input  wire [31:0] I_CSR_WDATA,
   output reg  [31:0] O_CSR_RDATA,
   output reg         O_CSR_VALID,
   output reg         O_CSR_ILLEGAL,
   // boundary identity inputs
   input  wire [3:0]  I_IMPL_PATCH,
   input  wire [31:0] I_HART_NUMBER,
   // pipeline and bus event pulses
   input  wire        I_EVT_RETIRED_OPS,
   input  wire        I_EVT_RETIRED_SHORT_OPS,
   input  wire        I_EVT_JUMP,
   input  wire        I_EVT_BRANCH,
   input  wire        I_EVT_COND_TRANSFER_TAKEN,
   input  wire        I_EVT_IRQ_ACCEPTED,
   input  wire        I_EVT_DATA_READ,
   input  wire        I_EVT_DATA_WRITE,
   input  wire        I_EVT_FETCH_STARVE,
   input  wire        I_EVT_DECODE_STARVE,
   input  wire        I_EVT_EXECUTE_STARVE,
   input  wire        I_EVT_WRITEBACK_STARVE,
   input  wire        I_EVT_LOAD_USE_HOLD,
   input  wire        I_EVT_JUMP_REG_HOLD,
   input  wire        I_EVT_WRITEBACK_MEM_HOLD
);

   localparam N = EVENT_COUNTER_QUANTITY;
   localparam NS = (N > 0) ? N : 1;

   reg  [63:0] cycle_q;
   reg  [63:0] retired_q;
   reg  [63:0] evt_cnt_q [0:NS-1];
   reg  [15:0] evt_sel_q [0:NS-1];
   reg  [31:0] inhibit_q;
   wire [15:0] evt_vec;
   wire        wr;
   wire [11:0] a;
   integer     k;

   // event number k sits on bit k
   assign evt_vec[`EVT_CYCLES]           = 1'b1;
   assign evt_vec[`EVT_RETIRED_OPS]      = I_EVT_RETIRED_OPS;
   assign evt_vec[`EVT_RETIRED_SHORT]    = I_EVT_RETIRED_SHORT_OPS;
   assign evt_vec[`EVT_JUMP]             = I_EVT_JUMP;
   assign evt_vec[`EVT_BRANCH]           = I_EVT_BRANCH;
   assign evt_vec[`EVT_EVT_COND_TRANSFER_TAKEN]     = I_EVT_COND_TRANSFER_TAKEN;
   assign evt_vec[`EVT_IRQ_ACCEPTED]     = I_EVT_IRQ_ACCEPTED;
   assign evt_vec[`EVT_DATA_READ]        = I_EVT_DATA_READ;
   assign evt_vec[`EVT_DATA_WRITE]       = I_EVT_DATA_WRITE;
   assign evt_vec[`EVT_FETCH_STARVE]     = I_EVT_FETCH_STARVE;
   assign evt_vec[`EVT_DECODE_STARVE]    = I_EVT_DECODE_STARVE;
   assign evt_vec[`EVT_EXECUTE_STARVE]   = I_EVT_EXECUTE_STARVE;
   assign evt_vec[`EVT_WRITEBACK_STARVE] = I_EVT_WRITEBACK_STARVE;
   assign evt_vec[`EVT_LOAD_USE_HOLD]    = I_EVT_LOAD_USE_HOLD;
   assign evt_vec[`EVT_JUMP_REG_HOLD]    = I_EVT_JUMP_REG_HOLD;
   assign evt_vec[`EVT_WB_MEM_HOLD]      = I_EVT_WRITEBACK_MEM_HOLD;

   assign wr = I_CSR_EN & I_CSR_WE;
   assign a  = I_CSR_ADDR;

   // counters and control; all on the gated clock, so sleep freezes them
   always @(posedge I_REF_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         cycle_q   <= `COUNTER_RESET;
         retired_q <= `COUNTER_RESET;
         inhibit_q <= `INHIBIT_RESET;
         for (k = 0; k < NS; k = k + 1)
         begin
            evt_cnt_q[k] <= `COUNTER_RESET;
            evt_sel_q[k] <= `EVENT_SEL_RESET;
         end
      end
      else
      begin
         // a write to either half suppresses that cycle's increment; the other half holds
         if (wr && a == `ADDR_CYCLE_LOW)
            cycle_q[31:0] <= I_CSR_WDATA;
         else if (wr && a == `ADDR_CYCLE_HIGH)
            cycle_q[63:32] <= I_CSR_WDATA;
         else if (!inhibit_q[`INHIBIT_BIT_CYCLE])
            cycle_q <= cycle_q + 64'h1;
         if (wr && a == `ADDR_RETIRED_LOW)
            retired_q[31:0] <= I_CSR_WDATA;
         else if (wr && a == `ADDR_RETIRED_HIGH)
            retired_q[63:32] <= I_CSR_WDATA;
         else if (!inhibit_q[`INHIBIT_BIT_RETIRED] && I_EVT_RETIRED_OPS)
            retired_q <= retired_q + 64'h1;
         if (wr && a == `ADDR_INHIBIT_MASK)
            inhibit_q <= I_CSR_WDATA;
         for (k = 0; k < N; k = k + 1)
         begin
            if (wr && a == `ADDR_EVENT_LOW_BASE + k[11:0])
               evt_cnt_q[k][31:0] <= I_CSR_WDATA;
            else if (wr && a == `ADDR_EVENT_HIGH_BASE + k[11:0])
               evt_cnt_q[k][63:32] <= I_CSR_WDATA;
            else if (!inhibit_q[k+3] && |(evt_sel_q[k] & evt_vec))
               evt_cnt_q[k] <= evt_cnt_q[k] + 64'h1;
            if (wr && a == `ADDR_EVENT_SEL_BASE + k[11:0])
               evt_sel_q[k] <= I_CSR_WDATA[`EVENT_SEL_WIDTH-1:0];
         end
      end
   end

   // read path; reads have no side effect on any counter
   reg  [31:0] rd_d;
   reg         ill_d;
   reg  [4:0]  idx;
   integer     j;
   always @*
   begin
      rd_d  = 32'h00000000;
      ill_d = 1'b0;
      idx   = 5'h00;
      if ((a >= `ADDR_EVENT_LOW_BASE && a <= `ADDR_EVENT_LOW_LAST) ||
          (a >= `ADDR_U_EVENT_LOW && a <= `ADDR_U_EVENT_LOW_END))
      begin
         idx = a[4:0] - 5'h03;
         for (j = 0; j < N; j = j + 1)
            if (idx == j[4:0])
               rd_d = evt_cnt_q[j][31:0];
      end
      else if ((a >= `ADDR_EVENT_HIGH_BASE && a <= `ADDR_EVENT_HIGH_LAST) ||
               (a >= `ADDR_U_EVENT_HIGH && a <= `ADDR_U_EVENT_HI_END))
      begin
         idx = a[4:0] - 5'h03;
         for (j = 0; j < N; j = j + 1)
            if (idx == j[4:0])
               rd_d = evt_cnt_q[j][63:32];
      end
      else if (a >= `ADDR_EVENT_SEL_BASE && a <= `ADDR_EVENT_SEL_LAST)
      begin
         idx = a[4:0] - 5'h03;
         for (j = 0; j < N; j = j + 1)
            if (idx == j[4:0])
               rd_d = {16'h0000, evt_sel_q[j]};
      end
      else
      begin
         case (a)
            `ADDR_INHIBIT_MASK:
               rd_d = inhibit_q;
            `ADDR_CYCLE_LOW, `ADDR_U_CYCLE_LOW:
               rd_d = cycle_q[31:0];
            `ADDR_CYCLE_HIGH, `ADDR_U_CYCLE_HIGH:
               rd_d = cycle_q[63:32];
            `ADDR_RETIRED_LOW, `ADDR_U_RETIRED_LOW:
               rd_d = retired_q[31:0];
            `ADDR_RETIRED_HIGH, `ADDR_U_RETIRED_HIGH:
               rd_d = retired_q[63:32];
            `ADDR_U_TIME_LOW, `ADDR_U_TIME_HIGH:
               ill_d = 1'b1;
            `ADDR_MAKER_ID:
               rd_d = {MAKER_BANK_COUNT, MAKER_CODE_BYTE};
            `ADDR_ARCH_ID:
               rd_d = ARCH_ID_VALUE;
            `ADDR_IMPL_VERSION:
               rd_d = {12'h000, IMPL_MAJOR, 4'h0, IMPL_MINOR,
                       4'h0, I_IMPL_PATCH};
            `ADDR_HART_NUMBER:
               rd_d = I_HART_NUMBER;
            `ADDR_CONFIG_PTR:
               rd_d = `CONFIG_PTR_VALUE;
            default:
               rd_d = 32'h00000000;
         endcase
      end
      // user shadows and identity registers refuse writes
      if (wr && (a[11:8] == 4'hc || a[11:8] == 4'hf))
         ill_d = 1'b1;
   end

   always @(posedge I_REF_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         O_CSR_RDATA   <= 32'h00000000;
         O_CSR_VALID   <= 1'b0;
         O_CSR_ILLEGAL <= 1'b0;
      end
      else
      begin
         O_CSR_VALID   <= I_CSR_EN;
         O_CSR_ILLEGAL <= I_CSR_EN & ill_d;
         O_CSR_RDATA   <= (I_CSR_EN & ~ill_d) ? rd_d : 32'h00000000;
      end
   end

endmodule

// ### perf_counter_csr_unit_monitor.sv
// assertions on the csr port of the counter unit
`timescale 1ns/1ps
module perf_counter_csr_unit_monitor
#(
   parameter        EVENT_COUNTER_QUANTITY = 1,
   parameter [24:0] MAKER_BANK_COUNT       = 25'h0000001,
   parameter [6:0]  MAKER_CODE_BYTE        = 7'h55,
   parameter [31:0] ARCH_ID_VALUE          = 32'h0000abcd,
   parameter [3:0]  IMPL_MAJOR             = 4'h0,
   parameter [3:0]  IMPL_MINOR             = 4'h0
)
(
   input wire        I_REF_CLK,
   input wire        I_RST,
   input wire        I_CSR_EN,
   input wire        I_CSR_WE,
   input wire [11:0] I_CSR_ADDR,
   input wire [31:0] O_CSR_RDATA,
   input wire        O_CSR_VALID,
   input wire        O_CSR_ILLEGAL,
   input wire [3:0]  I_IMPL_PATCH,
   input wire [31:0] I_HART_NUMBER
);
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_RST);
   wire rd = I_CSR_EN && !I_CSR_WE;
   access_answer_a: assert property (I_CSR_EN |=> O_CSR_VALID)
      else $error("access without answer");
   idle_quiet_a: assert property (!I_CSR_EN |-> ##1 !O_CSR_VALID)
      else $error("answer without access");
   time_trap_a: assert property (I_CSR_EN && (I_CSR_ADDR == 12'hc01 ||
      I_CSR_ADDR == 12'hc81) |=> O_CSR_ILLEGAL && O_CSR_RDATA == 32'h0)
      else $error("time access not trapped");
   shadow_ro_a: assert property (I_CSR_EN && I_CSR_WE &&
      I_CSR_ADDR[11:8] == 4'hc |=> O_CSR_ILLEGAL) else $error("shadow write");
   maker_id_a: assert property (rd && I_CSR_ADDR == 12'hf11 |=>
      O_CSR_RDATA == {MAKER_BANK_COUNT, MAKER_CODE_BYTE}) else $error("maker");
   arch_id_a: assert property (rd && I_CSR_ADDR == 12'hf12 |=>
      O_CSR_RDATA == ARCH_ID_VALUE) else $error("arch id");
   impl_id_a: assert property (rd && I_CSR_ADDR == 12'hf13 |=> O_CSR_RDATA ==
      {12'h0, IMPL_MAJOR, 4'h0, IMPL_MINOR, 4'h0, $past(I_IMPL_PATCH)})
      else $error("impl id");
   hart_id_a: assert property (rd && I_CSR_ADDR == 12'hf14 |=>
      O_CSR_RDATA == $past(I_HART_NUMBER)) else $error("hart number");
   absent_zero_a: assert property (rd && I_CSR_ADDR <= 12'hb1f &&
      I_CSR_ADDR >= 12'hb03 + EVENT_COUNTER_QUANTITY |=> O_CSR_RDATA == 32'h0)
      else $error("absent counter not zero");
   cover property (rd && I_CSR_ADDR == 12'hc00);
   cover property (I_CSR_EN && I_CSR_WE && I_CSR_ADDR == 12'h320);
   cover property (O_CSR_ILLEGAL);
endmodule

// ### perf_counter_regs.vh
// register addresses, field positions and reset values for the counter unit
`ifndef PERF_COUNTER_REGS_VH
`define PERF_COUNTER_REGS_VH
`define ADDR_INHIBIT_MASK    12'h320
`define ADDR_EVENT_SEL_BASE  12'h323
`define ADDR_EVENT_SEL_LAST  12'h33f
`define ADDR_CYCLE_LOW       12'hb00
`define ADDR_RETIRED_LOW     12'hb02
`define ADDR_EVENT_LOW_BASE  12'hb03
`define ADDR_EVENT_LOW_LAST  12'hb1f
`define ADDR_CYCLE_HIGH      12'hb80
`define ADDR_RETIRED_HIGH    12'hb82
`define ADDR_EVENT_HIGH_BASE 12'hb83
`define ADDR_EVENT_HIGH_LAST 12'hb9f
`define ADDR_U_CYCLE_LOW     12'hc00
`define ADDR_U_TIME_LOW      12'hc01
`define ADDR_U_RETIRED_LOW   12'hc02
`define ADDR_U_EVENT_LOW     12'hc03
`define ADDR_U_EVENT_LOW_END 12'hc1f
`define ADDR_U_CYCLE_HIGH    12'hc80
`define ADDR_U_TIME_HIGH     12'hc81
`define ADDR_U_RETIRED_HIGH  12'hc82
`define ADDR_U_EVENT_HIGH    12'hc83
`define ADDR_U_EVENT_HI_END  12'hc9f
`define ADDR_MAKER_ID        12'hf11
`define ADDR_ARCH_ID         12'hf12
`define ADDR_IMPL_VERSION    12'hf13
`define ADDR_HART_NUMBER     12'hf14
`define ADDR_CONFIG_PTR      12'hf15
`define INHIBIT_BIT_CYCLE    0
`define INHIBIT_BIT_RETIRED  2
`define INHIBIT_RESET        32'hffffffff
`define COUNTER_RESET        64'h0000000000000000
`define EVENT_SEL_WIDTH      16
`define EVENT_SEL_RESET      16'h0000
`define IMPL_MAJOR_MSB       19
`define IMPL_MAJOR_LSB       16
`define IMPL_MINOR_MSB       11
`define IMPL_MINOR_LSB       8
`define IMPL_PATCH_MSB       3
`define IMPL_PATCH_LSB       0
`define MAKER_BANK_LSB       7
`define CONFIG_PTR_VALUE     32'h00000000
`define EVT_CYCLES           0
`define EVT_RETIRED_OPS      1
`define EVT_RETIRED_SHORT    2
`define EVT_JUMP             3
`define EVT_BRANCH           4
`define EVT_EVT_COND_TRANSFER_TAKEN     5
`define EVT_IRQ_ACCEPTED     6
`define EVT_DATA_READ        7
`define EVT_DATA_WRITE       8
`define EVT_FETCH_STARVE     9
`define EVT_DECODE_STARVE    10
`define EVT_EXECUTE_STARVE   11
`define EVT_WRITEBACK_STARVE 12
`define EVT_LOAD_USE_HOLD    13
`define EVT_JUMP_REG_HOLD    14
`define EVT_WB_MEM_HOLD      15
`endif

// ### perf_event_source.sv
// pipeline event source: random per-cycle event levels while enabled
`timescale 1ns/1ps
module perf_event_source
(
   input  wire        i_clk,
   input  wire        i_en,
   output reg  [15:1] o_evt
);
   // levels move on the falling edge, clear of the sampling edge
   always @(negedge i_clk)
      o_evt <= i_en ? 15'($urandom) : 15'h0;
endmodule

// ### test_perf_counter_csr_unit.sv
// self-checking bench for the performance counter unit
`timescale 1ns/1ps
`include "perf_counter_regs.vh"
module test_perf_counter_csr_unit;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg         en = 1'b0;
   reg         we = 1'b0;
   reg  [11:0] addr = 12'h0;
   reg  [31:0] wdata = 32'h0;
   reg  [31:0] hart = 32'h0;
   reg         ev_en = 1'b0;
   reg  [15:0] sel;
   reg  [31:0] rd_v;
   reg  [31:0] first;
   reg         ill_v;
   wire [31:0] rdata;
   wire        valid;
   wire        ill;
   wire [15:1] evt;
   integer     err_count = 0;
   integer     n_tests = 0;
   integer     e;
   integer     k;
   integer     tally;
   integer     tret;
   always #25 clk = ~clk;
   perf_event_source i_src (.i_clk(clk), .i_en(ev_en), .o_evt(evt));
   perf_counter_csr_unit i_dut (.I_REF_CLK(clk), .I_RST(rst), .I_CSR_EN(en),
      .I_CSR_WE(we), .I_CSR_ADDR(addr), .I_CSR_WDATA(wdata),
      .O_CSR_RDATA(rdata), .O_CSR_VALID(valid), .O_CSR_ILLEGAL(ill),
      .I_IMPL_PATCH(4'h5), .I_HART_NUMBER(hart),
      .I_EVT_RETIRED_OPS(evt[1]), .I_EVT_RETIRED_SHORT_OPS(evt[2]),
      .I_EVT_JUMP(evt[3]), .I_EVT_BRANCH(evt[4]),
      .I_EVT_COND_TRANSFER_TAKEN(evt[5]), .I_EVT_IRQ_ACCEPTED(evt[6]),
      .I_EVT_DATA_READ(evt[7]), .I_EVT_DATA_WRITE(evt[8]),
      .I_EVT_FETCH_STARVE(evt[9]), .I_EVT_DECODE_STARVE(evt[10]),
      .I_EVT_EXECUTE_STARVE(evt[11]), .I_EVT_WRITEBACK_STARVE(evt[12]),
      .I_EVT_LOAD_USE_HOLD(evt[13]), .I_EVT_JUMP_REG_HOLD(evt[14]),
      .I_EVT_WRITEBACK_MEM_HOLD(evt[15]));
   task chk(input string name, input [31:0] exp, input [31:0] got);
      begin
         n_tests = n_tests + 1;
         if (got !== exp)
         begin
            err_count = err_count + 1;
            $display("ERROR %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   // one access; answer taken at the falling edge, half a cycle after the access edge
   task csr(input w, input [11:0] a, input [31:0] d);
      begin
         @(negedge clk);
         en = 1'b1;
         we = w;
         addr = a;
         wdata = d;
         @(negedge clk);
         en = 1'b0;
         rd_v = rdata;
         ill_v = ill;
         chk("valid", 32'h1, {31'h0, valid});
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", n_tests, err_count);
         if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // guard against a hang
   initial
   begin
      #200000;
      err_count = err_count + 1;
      complete_run;
   end
   initial
   begin
      void'($urandom(32'hd2a3));
      hart = $urandom;
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      csr(0, `ADDR_INHIBIT_MASK, 0);
      chk("inhibit", `INHIBIT_RESET, rd_v);
      csr(0, `ADDR_U_CYCLE_LOW, 0);
      chk("cycle", 32'h0, rd_v);
      csr(0, `ADDR_HART_NUMBER, 0);
      chk("hart", hart, rd_v);
      csr(0, `ADDR_IMPL_VERSION, 0);
      chk("impl", 32'h5, rd_v);
      csr(0, `ADDR_MAKER_ID, 0);
      chk("maker", {25'h1, 7'h55}, rd_v);
      csr(1, `ADDR_ARCH_ID, 32'h0);
      chk("arch_wr", 32'h1, {31'h0, ill_v});
      csr(0, `ADDR_ARCH_ID, 0);
      chk("arch", 32'h0000abcd, rd_v);
      csr(0, `ADDR_U_TIME_LOW, 0);
      chk("time", 32'h1, {31'h0, ill_v});
      csr(0, `ADDR_U_TIME_HIGH, 0);
      chk("timeh", 32'h1, {31'h0, ill_v});
      csr(0, 12'hb04, 0);
      chk("absent", 32'h0, rd_v);
      csr(0, 12'hc84, 0);
      chk("absent_u", 32'h0, rd_v);
      csr(1, `ADDR_CYCLE_HIGH, 32'h7);
      csr(1, `ADDR_CYCLE_LOW, 32'hffffffe0);
      csr(0, `ADDR_CYCLE_HIGH, 0);
      chk("half", 32'h7, rd_v);
      csr(1, `ADDR_INHIBIT_MASK, ~32'h1);
      csr(0, `ADDR_U_CYCLE_LOW, 0);
      first = rd_v;
      csr(0, `ADDR_U_CYCLE_LOW, 0);
      chk("step", first + 32'h2, rd_v);
      repeat (40) @(negedge clk);
      csr(0, `ADDR_U_CYCLE_HIGH, 0);
      chk("carry", 32'h8, rd_v);
      // an empty selector first, then events 1 to 15 in turn
      for (e = 0; e < 16; e = e + 1)
      begin
         sel = (e == 0) ? 16'h0 : (16'h1 << e);
         csr(1, `ADDR_INHIBIT_MASK, `INHIBIT_RESET);
         csr(1, `ADDR_EVENT_SEL_BASE, {16'h0, sel});
         csr(1, `ADDR_EVENT_LOW_BASE, 32'h0);
         csr(1, `ADDR_RETIRED_LOW, 32'h0);
         csr(1, `ADDR_INHIBIT_MASK, ~32'hc);
         tally = 0;
         tret = 0;
         for (k = 0; k < 30; k = k + 1)
         begin
            @(negedge clk);
            ev_en <= (k < 26);
            @(posedge clk);
            tally = tally + |({evt, 1'b0} & sel);
            tret = tret + evt[1];
         end
         csr(1, `ADDR_INHIBIT_MASK, `INHIBIT_RESET);
         csr(0, `ADDR_U_EVENT_LOW, 0);
         chk("event", tally, rd_v);
         csr(0, `ADDR_U_RETIRED_LOW, 0);
         chk("retired", tret, rd_v);
      end
      complete_run;
   end
endmodule
bind perf_counter_csr_unit perf_counter_csr_unit_monitor
   #(.EVENT_COUNTER_QUANTITY(EVENT_COUNTER_QUANTITY)) i_mon (
   .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_CSR_EN(I_CSR_EN),
   .I_CSR_WE(I_CSR_WE), .I_CSR_ADDR(I_CSR_ADDR), .O_CSR_RDATA(O_CSR_RDATA),
   .O_CSR_VALID(O_CSR_VALID), .O_CSR_ILLEGAL(O_CSR_ILLEGAL),
   .I_IMPL_PATCH(I_IMPL_PATCH), .I_HART_NUMBER(I_HART_NUMBER));
